/* File: pbwg_top.sv */
// APB bridge that stalls the CPU on accesses to wait-generating peripheral registers
`timescale 1ns/1ps
module pbwg_top
(
  input  wire logic                            MCLK_IN,
  input  wire logic                            RESET_IN,
  input  wire logic                            PSEL_IN,
  input  wire logic                            PENABLE_IN,
  input  wire logic                            PWRITE_IN,
  input  wire logic [pbwg_pkg::ADDR_W-1:0]     PADDR_IN,
  input  wire logic [pbwg_pkg::DATA_W-1:0]     PWDATA_IN,
  input  wire logic [pbwg_pkg::SFR_W-1:0]      SERIAL0_STATUS_IN,
  input  wire logic [pbwg_pkg::SFR_W-1:0]      SERIAL6_STATUS_IN,
  input  wire logic [pbwg_pkg::RESULT_W-1:0]   CONV_RESULT_IN,
  output logic                                 PREADY_OUT,
  output logic                                 PSLVERR_OUT,
  output logic      [pbwg_pkg::DATA_W-1:0]     PRDATA_OUT,
  output logic                                 CPU_STALL_OUT,
  output logic      [pbwg_pkg::SFR_W-1:0]      WATCHDOG_MODE_OUT,
  output logic      [pbwg_pkg::SFR_W-1:0]      CONV_MODE_OUT,
  output logic      [pbwg_pkg::SFR_W-1:0]      CONV_CHANNEL_OUT,
  output logic      [pbwg_pkg::SFR_W-1:0]      CONV_CMP_MODE_OUT,
  output logic      [pbwg_pkg::SFR_W-1:0]      CONV_CMP_THRESH_OUT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pbwg_wait_if wait_bus ();

  pbwg_pkg::pbwg_state_t                state_reg;
  pbwg_pkg::pbwg_state_t                state_next;
  logic [pbwg_pkg::SFR_W-1:0]           serial0_meta_reg;
  logic [pbwg_pkg::SFR_W-1:0]           serial0_sync_reg;
  logic [pbwg_pkg::SFR_W-1:0]           serial6_meta_reg;
  logic [pbwg_pkg::SFR_W-1:0]           serial6_sync_reg;
  logic [pbwg_pkg::RESULT_W-1:0]        result_meta_reg;
  logic [pbwg_pkg::RESULT_W-1:0]        result_sync_reg;
  logic [pbwg_pkg::SFR_W-1:0]           watchdog_mode_reg;
  logic [pbwg_pkg::SFR_W-1:0]           converter_mode_reg;
  logic [pbwg_pkg::SFR_W-1:0]           converter_channel_select;
  logic [pbwg_pkg::SFR_W-1:0]           converter_compare_mode;
  logic [pbwg_pkg::SFR_W-1:0]           converter_compare_threshold;
  logic [3:0]                           clock_config_reg;
  logic [pbwg_pkg::WAIT_W-1:0]          last_wait_reg;
  logic                                 violation_reg;
  logic [pbwg_pkg::TOTAL_W-1:0]         wait_total_reg;
  logic                                 pready_reg;
  logic                                 pslverr_reg;
  logic [pbwg_pkg::DATA_W-1:0]          prdata_reg;
  logic                                 stall_reg;
  logic                                 setup_cycle;
  logic                                 access_done;
  logic                                 mapped;
  logic [pbwg_pkg::WAIT_W-1:0]          converter_base;
  logic [pbwg_pkg::WAIT_W-1:0]          wait_need;
  logic [pbwg_pkg::DATA_W-1:0]          read_value;
  logic                                 converter_clock_select_bit;
  logic                                 main_clock_stop_flag;
  logic [2:0]                           cpu_div;

  // ****************************************************************
  // Peripheral-side inputs
  // ****************************************************************
  // Peripheral runs on an unrelated clock; two flops before any use
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      serial0_meta_reg <= pbwg_pkg::RST_SFR;
      serial0_sync_reg <= pbwg_pkg::RST_SFR;
      serial6_meta_reg <= pbwg_pkg::RST_SFR;
      serial6_sync_reg <= pbwg_pkg::RST_SFR;
      result_meta_reg  <= '0;
      result_sync_reg  <= '0;
    end
    else
    begin
      serial0_meta_reg <= SERIAL0_STATUS_IN;
      serial0_sync_reg <= serial0_meta_reg;
      serial6_meta_reg <= SERIAL6_STATUS_IN;
      serial6_sync_reg <= serial6_meta_reg;
      result_meta_reg  <= CONV_RESULT_IN;
      result_sync_reg  <= result_meta_reg;
    end
  end

  // ****************************************************************
  // Converter wait calculation
  // ****************************************************************
  // Loose control bits
  assign converter_clock_select_bit = converter_mode_reg[pbwg_pkg::CONV_CLK_SEL_BIT];
  assign main_clock_stop_flag       = clock_config_reg[pbwg_pkg::CFG_MAIN_STOP_BIT];
  assign cpu_div = (clock_config_reg[pbwg_pkg::CFG_DIV_LSB +: pbwg_pkg::CFG_DIV_W]
                    > pbwg_pkg::CPU_DIV_MAX) ? pbwg_pkg::CPU_DIV_MAX
                   : clock_config_reg[pbwg_pkg::CFG_DIV_LSB +: pbwg_pkg::CFG_DIV_W];

  // Ratio is a power of two, so any fraction is one half or one quarter; it is dropped
  function automatic logic [pbwg_pkg::WAIT_W-1:0] pbwg_converter_wait
  (
    input logic       clk_sel,
    input logic [2:0] div
  );
    logic [2:0] exp_val;
    exp_val = clk_sel ? pbwg_pkg::MACRO_EXP_FAST : pbwg_pkg::MACRO_EXP_SLOW;
    if (div > exp_val)
      pbwg_converter_wait = pbwg_pkg::WAIT_ONE;
    else
      pbwg_converter_wait = 4'((4'h1 << (exp_val - div)) + 4'h1);
  endfunction

  assign converter_base = pbwg_converter_wait(converter_clock_select_bit, cpu_div);

  // ****************************************************************
  // Address decode and wait need
  // ****************************************************************
  // Wait depends on register and direction; unlisted accesses add none
  always_comb
  begin
    wait_need = pbwg_pkg::WAIT_NONE;
    mapped    = 1'b1;
    case (PADDR_IN)
      pbwg_pkg::OFS_WATCHDOG_MODE:
        if (PWRITE_IN)
          wait_need = pbwg_pkg::WAIT_WATCHDOG;
      pbwg_pkg::OFS_SERIAL0_STATUS,
      pbwg_pkg::OFS_SERIAL6_STATUS:
        if (!PWRITE_IN)
          wait_need = pbwg_pkg::WAIT_SERIAL;
      pbwg_pkg::OFS_CONVERTER_MODE,
      pbwg_pkg::OFS_CHANNEL_SELECT,
      pbwg_pkg::OFS_COMPARE_MODE,
      pbwg_pkg::OFS_COMPARE_THRESHOLD:
        if (PWRITE_IN)
          wait_need = (converter_base == pbwg_pkg::WAIT_ONE) ? pbwg_pkg::WAIT_NONE
                      : converter_base;
      pbwg_pkg::OFS_CONVERSION_RESULT:
        if (!PWRITE_IN)
          wait_need = converter_base;
      pbwg_pkg::OFS_CLOCK_CONFIG,
      pbwg_pkg::OFS_WAIT_STATUS,
      pbwg_pkg::OFS_WAIT_TOTAL:
        wait_need = pbwg_pkg::WAIT_NONE;
      default:
        mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Transfer state machine
  // ****************************************************************
  assign setup_cycle = PSEL_IN && !PENABLE_IN;
  assign access_done = PSEL_IN && PENABLE_IN && pready_reg;

  // Timer is loaded at the decode edge
  // A running count means the access phase is still stalled; never reload it
  assign wait_bus.load  = setup_cycle && !wait_bus.busy;
  assign wait_bus.count = wait_need;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pbwg_pkg::PBWG_IDLE:
        if (setup_cycle)
          state_next = (wait_need == pbwg_pkg::WAIT_NONE) ? pbwg_pkg::PBWG_DONE
                       : pbwg_pkg::PBWG_WAIT;
      pbwg_pkg::PBWG_WAIT:
        if (wait_bus.done)
          state_next = pbwg_pkg::PBWG_DONE;
      pbwg_pkg::PBWG_DONE:
        if (setup_cycle)
          state_next = (wait_need == pbwg_pkg::WAIT_NONE) ? pbwg_pkg::PBWG_DONE
                       : pbwg_pkg::PBWG_WAIT;
        else
          state_next = pbwg_pkg::PBWG_IDLE;
      default:
        state_next = pbwg_pkg::PBWG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      state_reg <= pbwg_pkg::PBWG_IDLE;
    else
      state_reg <= state_next;
  end

  // Ready is held low for exactly the wait clocks of the access phase
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      pready_reg <= 1'b0;
    else
      pready_reg <= (state_next == pbwg_pkg::PBWG_DONE);
  end

  // Stall mirrors the pending wait so the instruction cannot finish early
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      stall_reg <= 1'b0;
    else
      stall_reg <= (state_next == pbwg_pkg::PBWG_WAIT);
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read mux; status is sampled only once the wait has let it settle
  always_comb
  begin
    read_value = pbwg_pkg::RST_RDATA;
    case (PADDR_IN)
      pbwg_pkg::OFS_WATCHDOG_MODE:     read_value[pbwg_pkg::SFR_W-1:0] = watchdog_mode_reg;
      pbwg_pkg::OFS_SERIAL0_STATUS:    read_value[pbwg_pkg::SFR_W-1:0] = serial0_sync_reg;
      pbwg_pkg::OFS_SERIAL6_STATUS:    read_value[pbwg_pkg::SFR_W-1:0] = serial6_sync_reg;
      pbwg_pkg::OFS_CONVERTER_MODE:    read_value[pbwg_pkg::SFR_W-1:0] = converter_mode_reg;
      pbwg_pkg::OFS_CHANNEL_SELECT:
        read_value[pbwg_pkg::SFR_W-1:0] = converter_channel_select;
      pbwg_pkg::OFS_COMPARE_MODE:
        read_value[pbwg_pkg::SFR_W-1:0] = converter_compare_mode;
      pbwg_pkg::OFS_COMPARE_THRESHOLD:
        read_value[pbwg_pkg::SFR_W-1:0] = converter_compare_threshold;
      pbwg_pkg::OFS_CONVERSION_RESULT:
        read_value[pbwg_pkg::RESULT_W-1:0] = result_sync_reg;
      pbwg_pkg::OFS_CLOCK_CONFIG:      read_value[3:0] = clock_config_reg;
      pbwg_pkg::OFS_WAIT_STATUS:
      begin
        read_value[pbwg_pkg::STAT_LAST_LSB +: pbwg_pkg::WAIT_W] = last_wait_reg;
        read_value[pbwg_pkg::STAT_VIOLATION_BIT]                = violation_reg;
      end
      pbwg_pkg::OFS_WAIT_TOTAL:
        read_value[pbwg_pkg::TOTAL_W-1:0] = wait_total_reg;
      default:
        read_value = pbwg_pkg::RST_RDATA;
    endcase
  end

  // Data and error are loaded together with ready
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      prdata_reg  <= pbwg_pkg::RST_RDATA;
      pslverr_reg <= 1'b0;
    end
    else if (state_next == pbwg_pkg::PBWG_DONE && !access_done)
    begin
      prdata_reg  <= PWRITE_IN ? pbwg_pkg::RST_RDATA : read_value;
      pslverr_reg <= !mapped;
    end
    else if (state_next != pbwg_pkg::PBWG_DONE)
    begin
      prdata_reg  <= pbwg_pkg::RST_RDATA;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= PWRITE_IN ? pbwg_pkg::RST_RDATA : read_value;
      pslverr_reg <= !mapped;
    end
  end

  // ****************************************************************
  // Write path
  // ****************************************************************
  // Writes land only at the completing edge, after any wait
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      watchdog_mode_reg           <= pbwg_pkg::RST_SFR;
      converter_mode_reg          <= pbwg_pkg::RST_SFR;
      converter_channel_select    <= pbwg_pkg::RST_SFR;
      converter_compare_mode      <= pbwg_pkg::RST_SFR;
      converter_compare_threshold <= pbwg_pkg::RST_SFR;
      clock_config_reg            <= pbwg_pkg::RST_CFG;
    end
    else if (access_done && PWRITE_IN)
    begin
      case (PADDR_IN)
        pbwg_pkg::OFS_WATCHDOG_MODE:
          watchdog_mode_reg <= PWDATA_IN[pbwg_pkg::SFR_W-1:0];
        pbwg_pkg::OFS_CONVERTER_MODE:
          converter_mode_reg <= PWDATA_IN[pbwg_pkg::SFR_W-1:0];
        pbwg_pkg::OFS_CHANNEL_SELECT:
          converter_channel_select <= PWDATA_IN[pbwg_pkg::SFR_W-1:0];
        pbwg_pkg::OFS_COMPARE_MODE:
          converter_compare_mode <= PWDATA_IN[pbwg_pkg::SFR_W-1:0];
        pbwg_pkg::OFS_COMPARE_THRESHOLD:
          converter_compare_threshold <= PWDATA_IN[pbwg_pkg::SFR_W-1:0];
        pbwg_pkg::OFS_CLOCK_CONFIG:
          clock_config_reg <= PWDATA_IN[3:0];
        default:
          clock_config_reg <= clock_config_reg;
      endcase
    end
  end

  // ****************************************************************
  // Wait bookkeeping
  // ****************************************************************
  // Last computed wait, captured at decode
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      last_wait_reg <= pbwg_pkg::WAIT_NONE;
    else if (wait_bus.load)
      last_wait_reg <= wait_need;
  end

  // Waits with the main clock stopped are a software fault; set beats clear
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      violation_reg <= 1'b0;
    else if (wait_bus.load && main_clock_stop_flag && wait_need != pbwg_pkg::WAIT_NONE)
      violation_reg <= 1'b1;
    else if (access_done && PWRITE_IN && PADDR_IN == pbwg_pkg::OFS_WAIT_STATUS
             && PWDATA_IN[pbwg_pkg::STAT_VIOLATION_BIT])
      violation_reg <= 1'b0;
  end

  // Running total of stalled CPU clocks, wraps
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      wait_total_reg <= pbwg_pkg::RST_TOTAL;
    else if (stall_reg)
      wait_total_reg <= wait_total_reg + 16'h0001;
  end

  // ****************************************************************
  // Wait timer
  // ****************************************************************
  pbwg_wait_timer u_wait_timer
  (
    .clk_in    (MCLK_IN),
    .rst_in    (RESET_IN),
    .wait_port (wait_bus.timer)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PREADY_OUT          = pready_reg;
  assign PSLVERR_OUT         = pslverr_reg;
  assign PRDATA_OUT          = prdata_reg;
  assign CPU_STALL_OUT       = stall_reg;
  assign WATCHDOG_MODE_OUT   = watchdog_mode_reg;
  assign CONV_MODE_OUT       = converter_mode_reg;
  assign CONV_CHANNEL_OUT    = converter_channel_select;
  assign CONV_CMP_MODE_OUT   = converter_compare_mode;
  assign CONV_CMP_THRESH_OUT = converter_compare_threshold;

endmodule

/* File: pbwg_pkg.sv */
// Constants, register map and types of the peripheral bus wait generator
package pbwg_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned SFR_W    = 8;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned WAIT_W   = 4;
  localparam int unsigned TOTAL_W  = 16;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_WATCHDOG_MODE     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SERIAL0_STATUS    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SERIAL6_STATUS    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CONVERTER_MODE    = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_SELECT    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_MODE      = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_THRESHOLD = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_CONVERSION_RESULT = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG      = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_WAIT_STATUS       = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_WAIT_TOTAL        = 12'h028;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CONV_CLK_SEL_BIT   = 5;
  localparam int unsigned CFG_DIV_LSB        = 0;
  localparam int unsigned CFG_DIV_W          = 3;
  localparam int unsigned CFG_MAIN_STOP_BIT  = 3;
  localparam int unsigned STAT_LAST_LSB      = 0;
  localparam int unsigned STAT_VIOLATION_BIT = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [SFR_W-1:0]   RST_SFR    = 8'h00;
  localparam logic [3:0]         RST_CFG    = 4'h0;
  localparam logic [TOTAL_W-1:0] RST_TOTAL  = 16'h0000;
  localparam logic [DATA_W-1:0]  RST_RDATA  = 32'h0000_0000;

  // ****************************************************************
  // Wait counts in CPU clocks, divider limit and converter clock exponents
  // ****************************************************************
  localparam logic [WAIT_W-1:0] WAIT_NONE     = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_WATCHDOG = 4'h3;
  localparam logic [WAIT_W-1:0] WAIT_SERIAL   = 4'h1;
  localparam logic [WAIT_W-1:0] WAIT_ONE      = 4'h1;
  localparam logic [2:0]        CPU_DIV_MAX   = 3'h4;
  localparam logic [2:0]        MACRO_EXP_FAST = 3'h2;
  localparam logic [2:0]        MACRO_EXP_SLOW = 3'h3;

  // ****************************************************************
  // Transfer state machine, Gray coded along idle, wait, done
  // ****************************************************************
  typedef enum logic [1:0]
  {
    PBWG_IDLE = 2'b00,
    PBWG_WAIT = 2'b01,
    PBWG_DONE = 2'b11
  } pbwg_state_t;

endpackage

/* File: pbwg_wait_if.sv */
// Handshake between the transfer control and the wait timer
`timescale 1ns/1ps
interface pbwg_wait_if;
  logic                          load;
  logic [pbwg_pkg::WAIT_W-1:0]   count;
  logic                          busy;
  logic                          done;

  modport ctrl
  (
    output load,
    output count,
    input  busy,
    input  done
  );

  modport timer
  (
    input  load,
    input  count,
    output busy,
    output done
  );
endinterface

/* File: pbwg_wait_timer.sv */
// Down counter of CPU wait clocks
`timescale 1ns/1ps
module pbwg_wait_timer
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  pbwg_wait_if.timer wait_port
);

  logic [pbwg_pkg::WAIT_W-1:0] cnt_reg;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Loaded in the setup cycle, counts one per CPU clock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cnt_reg <= pbwg_pkg::WAIT_NONE;
    else if (wait_port.load)
      cnt_reg <= wait_port.count;
    else if (cnt_reg != pbwg_pkg::WAIT_NONE)
      cnt_reg <= cnt_reg - pbwg_pkg::WAIT_ONE;
  end

  // Last wait clock is the one that carries a count of one
  assign wait_port.busy = (cnt_reg != pbwg_pkg::WAIT_NONE);
  assign wait_port.done = (cnt_reg == pbwg_pkg::WAIT_ONE);

endmodule

/* File: pbwg_chk.sv */
// Assertion checker for the peripheral bus wait generator ports
`timescale 1ns/1ps
module pbwg_chk
(
  input wire logic        MCLK_IN,
  input wire logic        RESET_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        CPU_STALL_OUT,
  input wire logic [7:0]  WATCHDOG_MODE_OUT
);
  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  logic       setup;
  logic       unmapped;
  logic [7:0] wd_lo;
  assign setup    = PSEL_IN && !PENABLE_IN;
  assign unmapped = (PADDR_IN[1:0] != 2'h0) || (PADDR_IN > 12'h028);
  assign wd_lo    = PWDATA_IN[7:0];
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);
  // Answers only inside an access phase
  AST_READY_IN_ACCESS: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("ready outside an access phase");
  AST_STALL_ONLY_WAIT: assert property (CPU_STALL_OUT |-> PENABLE_IN && !PREADY_OUT)
    else $error("stall outside wait cycles");
  AST_WDT_WAIT: assert property (setup && PWRITE_IN && PADDR_IN == 12'h000 |=>
    CPU_STALL_OUT [*3] ##1 (PREADY_OUT && !CPU_STALL_OUT))
    else $error("watchdog mode write wait wrong");
  AST_SERIAL_WAIT: assert property (setup && !PWRITE_IN && PADDR_IN inside {12'h004, 12'h008}
    |=> CPU_STALL_OUT ##1 (PREADY_OUT && !CPU_STALL_OUT))
    else $error("serial status read wait wrong");
  AST_PLAIN_NO_WAIT: assert property (setup && PADDR_IN == 12'h020 |=> PREADY_OUT)
    else $error("plain register access delayed");
  AST_UNMAPPED_ERR: assert property (setup && unmapped |=> PREADY_OUT && PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped access not refused at once");
  AST_RESULT_WAIT: assert property (setup && !PWRITE_IN && PADDR_IN == 12'h01c |=> CPU_STALL_OUT)
    else $error("result read without a wait");
  AST_CONV_BOUND: assert property (setup && PWRITE_IN
    && PADDR_IN inside {12'h00c, 12'h010, 12'h014, 12'h018} |=> ##[0:9] PREADY_OUT)
    else $error("converter write wait too long");
  AST_WDT_UPDATE: assert property (PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h000
    |=> WATCHDOG_MODE_OUT == $past(wd_lo))
    else $error("watchdog mode not written at completion");
  // Main scenarios reached
  COV_STALL: cover property (CPU_STALL_OUT [*8]);
  COV_ERR: cover property (PREADY_OUT && PSLVERR_OUT);
  COV_WDT: cover property (setup && PWRITE_IN && PADDR_IN == 12'h000);
endmodule

bind pbwg_top pbwg_chk i_chk
(
  .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT),
  .CPU_STALL_OUT(CPU_STALL_OUT), .WATCHDOG_MODE_OUT(WATCHDOG_MODE_OUT)
);

/* File: pbwg_cpu_model.sv */
// CPU side model issuing APB register transfers
`timescale 1ns/1ps
module pbwg_cpu_model
(
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out
);
  // Idle bus from time zero
  initial
  begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'hfff;
    pwdata_out  = 32'h0;
  end
  // One transfer; waits is -1 when the slave never answers
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output int waits);
    waits = -1;
    @(posedge clk_in);
    psel_out    <= 1'b1;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk_in);
      if (pready_in === 1'b1)
      begin
        waits = k;
        break;
      end
    end
    rd  = prdata_in;
    err = pslverr_in;
    // Inverted leftovers, so a stale bus never looks like a fresh request
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    paddr_out   <= ~a;
    pwdata_out  <= ~wd;
  endtask
endmodule

/* File: pbwg_top_tb.sv */
// Self-checking testbench for the peripheral bus wait generator
`timescale 1ns/1ps
module pbwg_top_tb;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ser0, ser6, wdt_mode, conv_mode, ch, cmp_mode, cmp_th;
  logic [9:0]  result;
  int          n_errors = 0;
  int          checks_done = 0;
  int          total = 0;

  pbwg_top i_dut
  (
    .MCLK_IN(mclk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .SERIAL0_STATUS_IN(ser0), .SERIAL6_STATUS_IN(ser6), .CONV_RESULT_IN(result),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .CPU_STALL_OUT(stall),
    .WATCHDOG_MODE_OUT(wdt_mode), .CONV_MODE_OUT(conv_mode), .CONV_CHANNEL_OUT(ch),
    .CONV_CMP_MODE_OUT(cmp_mode), .CONV_CMP_THRESH_OUT(cmp_th)
  );
  pbwg_cpu_model i_cpu
  (
    .clk_in(mclk), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata)
  );
  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Transfer plus check of wait count and error flag; settles before returning
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input int n, input logic e, output logic [31:0] rd);
    logic err;
    int   waits;
    i_cpu.xfer(w, a, wd, rd, err, waits);
    #1;
    if (waits < 0)
    begin
      n_errors++;
      stop_test();
    end
    else
    begin
      total += n;
      chk(32'(waits), 32'(n));
      chk({31'h0, err}, {31'h0, e});
    end
  endtask
  // Converter wait: macro over CPU period plus one, half and quarter clocks dropped
  function automatic int exp_b(input logic sel, input int d);
    int e;
    int dd;
    e  = sel ? 2 : 3;
    dd = (d > 4) ? 4 : d;
    return (dd <= e) ? (1 << (e - dd)) + 1 : 1;
  endfunction
  task automatic t_basic;
    logic [31:0] rd;
    chk({24'h0, wdt_mode}, 32'h0);
    acc(1'b1, 12'h000, 32'h0000_00a5, 3, 1'b0, rd);
    chk({24'h0, wdt_mode}, 32'h0000_00a5);
    acc(1'b0, 12'h000, 32'h0, 0, 1'b0, rd);
    chk(rd, 32'h0000_00a5);
    acc(1'b0, 12'h004, 32'h0, 1, 1'b0, rd);
    chk(rd, {24'h0, ser0});
    acc(1'b0, 12'h008, 32'h0, 1, 1'b0, rd);
    chk(rd, {24'h0, ser6});
  endtask
  task automatic t_converter;
    logic [31:0] rd;
    logic        sel;
    int          n;
    sel = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      for (int d = 0; d < 6; d++)
      begin
        // Main clock stop flag stays clear while wait registers are used
        acc(1'b1, 12'h020, 32'(d), 0, 1'b0, rd);
        n = exp_b(sel, d);
        acc(1'b1, 12'h010 + 12'(4 * (d % 3)), 32'(d), (n > 1) ? n : 0, 1'b0, rd);
        acc(1'b0, 12'h01c, 32'h0, n, 1'b0, rd);
        chk(rd, {22'h0, result});
      end
      // Last writes of the loop left 3, 4 and 5 in channel and compare settings
      chk({8'h0, cmp_th, cmp_mode, ch}, 32'h0005_0403);
      acc(1'b1, 12'h020, 32'h0, 0, 1'b0, rd);
      acc(1'b1, 12'h00c, 32'h20, exp_b(sel, 0), 1'b0, rd);
      chk({24'h0, conv_mode}, 32'h20);
      sel = 1'b1;
    end
  endtask
  task automatic t_refuse;
    logic [31:0] rd;
    // A wait with the main clock stopped is flagged but still inserted
    acc(1'b1, 12'h020, 32'h0000_0008, 0, 1'b0, rd);
    acc(1'b1, 12'h000, 32'h0000_00a5, 3, 1'b0, rd);
    acc(1'b0, 12'h024, 32'h0, 0, 1'b0, rd);
    chk(rd, 32'h0000_0103);
    acc(1'b1, 12'h024, 32'h0000_0100, 0, 1'b0, rd);
    acc(1'b1, 12'h020, 32'h0, 0, 1'b0, rd);
    acc(1'b0, 12'h024, 32'h0, 0, 1'b0, rd);
    chk(rd, 32'h0);
    acc(1'b0, 12'h02c, 32'h0, 0, 1'b1, rd);
    chk(rd, 32'h0);
    acc(1'b1, 12'h002, 32'h0000_00ff, 0, 1'b1, rd);
    acc(1'b1, 12'h004, 32'h0000_00ff, 0, 1'b0, rd);
    chk({24'h0, wdt_mode}, 32'h0000_00a5);
    acc(1'b0, 12'h028, 32'h0, 0, 1'b0, rd);
    chk(rd, 32'(total));
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    rst    = 1'b1;
    ser0   = 8'h3c;
    ser6   = 8'hc3;
    result = 10'h2b7;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_basic();
    t_converter();
    t_refuse();
    stop_test();
  end
endmodule
